// File: pkg/rswc_pkg.sv
// constants for the reset, suspend and wake control block
package rswc_pkg;
  // clock rate
  localparam int CLK_MHZ = 25;
  // cpu i/o addresses
  localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h26;
  localparam logic [7:0] ADDR_CLK_CFG    = 8'hf8;
  localparam logic [7:0] ADDR_STATUS     = 8'hff;
  // processor status and control fields
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_SENSE_BIT  = 2;
  localparam int ST_SUSP_BIT   = 3;
  localparam int ST_LVRBOR_BIT = 4;
  localparam int ST_WDR_BIT    = 6;
  localparam logic [7:0] STATUS_RST = 8'h11;
  // clock configuration fields
  localparam int CFG_EXT_EN_BIT = 0;
  localparam int CFG_LVR_DIS_BIT = 3;
  localparam int CFG_ADJ_LSB    = 4;
  localparam int CFG_ADJ_MSB    = 6;
  localparam int CFG_DLY_BIT    = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  // restart address
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // times in microseconds
  localparam int INT_START_US  = 2;
  localparam int INT_RESUME_US = 8;
  localparam int EXT_SHORT_US  = 128;
  localparam int EXT_LONG_US   = 4000;
  localparam int WDR_HOLD_US   = 2000;
  localparam int TSTART_US     = 1000;
  // derived cycle counts; short times only, long ones are top parameters
  localparam int INT_START_CYC  = INT_START_US * CLK_MHZ;
  localparam int INT_RESUME_CYC = INT_RESUME_US * CLK_MHZ;
  localparam int EXT_SHORT_CYC  = EXT_SHORT_US * CLK_MHZ;
  // delay counter and tick counter widths
  localparam int DLY_W  = 17;
  localparam int WT_W   = 16;
  localparam int WD_W   = 16;
  localparam logic [WT_W-1:0] WT_BASE_TICKS = 16'h0004;
  localparam logic [WD_W-1:0] WD_TIMEOUT_TICKS = 16'h0008;
  // sequencer states
  typedef enum logic [3:0] {
    SQ_HOLD, SQ_START, SQ_RUN, SQ_WDR, SQ_SUSPEND,
    SQ_INT_START, SQ_INT_DELAY, SQ_EXT_WAIT, SQ_EXT_DELAY
  } rswc_state_t;
endpackage

// File: hdl/rswc_watchdog.sv
// watchdog counter on the low-power tick
`timescale 1ns/1ps
`default_nettype none
module rswc_watchdog #(
  parameter logic [rswc_pkg::WD_W-1:0] TIMEOUT = rswc_pkg::WD_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic tick,
  input  wire logic run,
  input  wire logic clear,
  // rollover
  output logic      roll_r
);
  logic [rswc_pkg::WD_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      cnt_r  <= '0;
      roll_r <= 1'b0;
    end else if (run && tick) begin
      if (cnt_r == TIMEOUT - 1'b1) begin
        cnt_r  <= '0;
        roll_r <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 1'b1;
        roll_r <= 1'b0;
      end
    end else begin
      roll_r <= 1'b0;
    end
  end

  a_wdog_clear_zero: assert property (@(posedge clk) disable iff (rst)
    clear |=> cnt_r == '0 && !roll_r) else $error("watchdog not cleared");
  a_wdog_frozen: assert property (@(posedge clk) disable iff (rst)
    !run && !clear |=> $stable(cnt_r)) else $error("watchdog ran while stopped");
endmodule
`default_nettype wire

// File: hdl/rswc_wake_timer.sv
// periodic wake-up timer on the low-power tick
`timescale 1ns/1ps
`default_nettype none
module rswc_wake_timer #(
  parameter logic [rswc_pkg::WT_W-1:0] BASE = rswc_pkg::WT_BASE_TICKS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       tick,
  input  wire logic       en,
  input  wire logic [2:0] adj,
  // time-out
  output logic            expire_r
);
  logic [rswc_pkg::WT_W-1:0] cnt_r;
  logic [rswc_pkg::WT_W-1:0] period;

  assign period = rswc_pkg::WT_W'(BASE << adj);

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end else if (tick) begin
      if (cnt_r == period - 1'b1) begin
        cnt_r    <= '0;
        expire_r <= 1'b1;
      end else begin
        cnt_r    <= cnt_r + 1'b1;
        expire_r <= 1'b0;
      end
    end else begin
      expire_r <= 1'b0;
    end
  end

  a_wake_disable_reset: assert property (@(posedge clk) disable iff (rst)
    !en |=> cnt_r == '0 && !expire_r) else $error("wake timer kept count");
  a_wake_runs_enabled: assert property (@(posedge clk) disable iff (rst)
    en && tick && cnt_r < period - 1'b1 |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("wake timer did not advance");
endmodule
`default_nettype wire

// File: hdl/rswc_reset_suspend_wake.sv
// reset, suspend and wake-up sequencer with watchdog and wake timer
// Notes on behaviour
// - brown-out holds reset until supply above low-voltage level, then start-up, then 0
// - in suspend only brown-out resets; low-voltage reset disarmed
// - any write to watchdog clear register zeroes the watchdog counter
// - uncleared watchdog rolls over, resets the cpu and sets status bit 6
// - watchdog reset held two to four ms, then restart at address zero
// - writing the suspend bit puts the device into low-power state
// - suspend stops oscillators and timers except gpio, data receiver, wake timer
// - wake on gpio, wake timer, spi or other pending interrupt, or low data line
// - any enabled pending interrupt wakes; sense bit ignored
// - wake condition already present still enters suspend, then wakes after delay
// - run bit written with suspend; resume only when run bit set
// - after resume the next instruction runs before any interrupt
// - wake clock follows external enable bit as it stood at suspend entry
// - internal wake: clock within 2 us, then 8 us before resuming
// - setting external enable on internal clock halts until stable, then delay
// - external wake: start oscillator, wait stable, then resume delay
// - wake timer runs exactly while its interrupt enable is set
// - wake timer fires periodically; disable resets its count
// - adjust field bits 6:4 selects base wake time times two to the field
// - external resume delay 128 us when delay bit clear, 4 ms when set
`timescale 1ns/1ps
`default_nettype none
module rswc_reset_suspend_wake #(
  parameter int TSTART_CYC   = rswc_pkg::TSTART_US * rswc_pkg::CLK_MHZ,
  parameter int WDR_HOLD_CYC = rswc_pkg::WDR_HOLD_US * rswc_pkg::CLK_MHZ,
  parameter int EXT_LONG_CYC = rswc_pkg::EXT_LONG_US * rswc_pkg::CLK_MHZ,
  parameter logic [rswc_pkg::WT_W-1:0] WAKE_BASE_TICKS = rswc_pkg::WT_BASE_TICKS,
  parameter logic [rswc_pkg::WD_W-1:0] WDOG_TICKS      = rswc_pkg::WD_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // cpu i/o write port
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        cpu_instr_done,
  // supply monitors
  input  wire logic        brownout_reset,
  input  wire logic        low_voltage_reset,
  // oscillator and tick
  input  wire logic        ext_osc_stable,
  input  wire logic        lp_tick,
  // wake sources
  input  wire logic        gpio_int_pend,
  input  wire logic        spi_int_pend,
  input  wire logic        other_int_pend,
  input  wire logic        serial_data_line,
  input  wire logic        wake_timer_int_en,
  input  wire logic        wake_timer_pend_clr,
  // cpu control
  output logic             cpu_reset_r,
  output logic             cpu_run_r,
  output logic             irq_defer_r,
  output logic [15:0]      reset_vector_r,
  // clocks and power
  output logic             int_osc_on_r,
  output logic             ext_osc_on_r,
  output logic             ext_clk_sel_r,
  output logic             suspended_r,
  output logic             lvr_armed_r,
  // register views
  output logic [7:0]       status_r,
  output logic [7:0]       clk_cfg_r,
  output logic             wake_timer_pend_r
);
  rswc_pkg::rswc_state_t state_r;
  rswc_pkg::rswc_state_t state_nxt;
  logic [rswc_pkg::DLY_W-1:0] cnt_r;
  logic        cnt_zero;
  logic        wd_roll;
  logic        wt_expire;
  logic        wake_ext_r;
  logic        from_susp_r;
  logic        lvr_armed;
  logic        supply_trip;
  logic        wake_any;
  logic        wr_status;
  logic        wr_cfg;
  logic        wr_wdog;
  logic        ext_sel_nxt;

  // delay count loaded on entry to a timed state
  function automatic logic [rswc_pkg::DLY_W-1:0] load_for(
    input rswc_pkg::rswc_state_t st,
    input logic                  long_dly
  );
    int cyc;
    cyc = 1;
    case (st)
      rswc_pkg::SQ_START:     cyc = TSTART_CYC;
      rswc_pkg::SQ_WDR:       cyc = WDR_HOLD_CYC;
      rswc_pkg::SQ_INT_START: cyc = rswc_pkg::INT_START_CYC;
      rswc_pkg::SQ_INT_DELAY: cyc = rswc_pkg::INT_RESUME_CYC;
      rswc_pkg::SQ_EXT_DELAY: cyc = long_dly ? EXT_LONG_CYC : rswc_pkg::EXT_SHORT_CYC;
      default:                cyc = 1;
    endcase
    return rswc_pkg::DLY_W'(cyc - 1);
  endfunction

  // register strobes, taken only while the cpu executes
  assign wr_status = io_wr && state_r == rswc_pkg::SQ_RUN && io_addr == rswc_pkg::ADDR_STATUS;
  assign wr_cfg    = io_wr && state_r == rswc_pkg::SQ_RUN && io_addr == rswc_pkg::ADDR_CLK_CFG;
  assign wr_wdog   = io_wr && state_r == rswc_pkg::SQ_RUN
                     && io_addr == rswc_pkg::ADDR_WDOG_CLEAR;
  assign cnt_zero  = cnt_r == '0;

  // low-voltage detect off in suspend or when disabled
  assign lvr_armed = state_r != rswc_pkg::SQ_SUSPEND
                     && !clk_cfg_r[rswc_pkg::CFG_LVR_DIS_BIT];
  assign supply_trip = brownout_reset || (lvr_armed && low_voltage_reset);

  // wake sources, interrupt sense bit not consulted
  assign wake_any = gpio_int_pend || spi_int_pend || other_int_pend
                    || wake_timer_pend_r || !serial_data_line;

  // sequencer
  always_comb begin
    state_nxt = state_r;
    if (supply_trip) begin
      state_nxt = rswc_pkg::SQ_HOLD;
    end else begin
      case (state_r)
        rswc_pkg::SQ_HOLD: begin
          if (!low_voltage_reset) state_nxt = rswc_pkg::SQ_START;
        end
        rswc_pkg::SQ_START: begin
          if (cnt_zero) state_nxt = rswc_pkg::SQ_RUN;
        end
        rswc_pkg::SQ_RUN: begin
          if (wd_roll) begin
            state_nxt = rswc_pkg::SQ_WDR;
          end else if (wr_status && io_wdata[rswc_pkg::ST_SUSP_BIT]) begin
            state_nxt = rswc_pkg::SQ_SUSPEND;
          end else if (wr_cfg && io_wdata[rswc_pkg::CFG_EXT_EN_BIT] && !ext_clk_sel_r) begin
            state_nxt = rswc_pkg::SQ_EXT_WAIT;
          end
        end
        rswc_pkg::SQ_WDR: begin
          if (cnt_zero) state_nxt = rswc_pkg::SQ_RUN;
        end
        rswc_pkg::SQ_SUSPEND: begin
          if (wake_any && status_r[rswc_pkg::ST_RUN_BIT]) begin
            state_nxt = wake_ext_r ? rswc_pkg::SQ_EXT_WAIT
                                   : rswc_pkg::SQ_INT_START;
          end
        end
        rswc_pkg::SQ_INT_START: begin
          if (cnt_zero) state_nxt = rswc_pkg::SQ_INT_DELAY;
        end
        rswc_pkg::SQ_INT_DELAY: begin
          if (cnt_zero) state_nxt = rswc_pkg::SQ_RUN;
        end
        rswc_pkg::SQ_EXT_WAIT: begin
          if (ext_osc_stable) state_nxt = rswc_pkg::SQ_EXT_DELAY;
        end
        rswc_pkg::SQ_EXT_DELAY: begin
          if (cnt_zero) state_nxt = rswc_pkg::SQ_RUN;
        end
        default: state_nxt = rswc_pkg::SQ_HOLD;
      endcase
    end
  end

  // clock mode after this cycle
  always_comb begin
    ext_sel_nxt = ext_clk_sel_r;
    if (state_nxt == rswc_pkg::SQ_HOLD || state_nxt == rswc_pkg::SQ_INT_START) begin
      ext_sel_nxt = 1'b0;
    end else if (state_nxt == rswc_pkg::SQ_EXT_DELAY) begin
      ext_sel_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= rswc_pkg::SQ_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= load_for(state_nxt, clk_cfg_r[rswc_pkg::CFG_DLY_BIT]);
    end else if (!cnt_zero) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // processor status and control
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= rswc_pkg::STATUS_RST;
    end else if (state_nxt == rswc_pkg::SQ_HOLD && state_r != rswc_pkg::SQ_HOLD) begin
      status_r <= rswc_pkg::STATUS_RST;
    end else if (state_nxt == rswc_pkg::SQ_WDR) begin
      status_r[rswc_pkg::ST_WDR_BIT] <= 1'b1;
      status_r[rswc_pkg::ST_SUSP_BIT] <= 1'b0;
    end else if (state_r == rswc_pkg::SQ_SUSPEND && state_nxt != rswc_pkg::SQ_SUSPEND) begin
      status_r[rswc_pkg::ST_SUSP_BIT] <= 1'b0;
    end else if (wr_status) begin
      status_r[rswc_pkg::ST_RUN_BIT]   <= io_wdata[rswc_pkg::ST_RUN_BIT];
      status_r[rswc_pkg::ST_SENSE_BIT] <= io_wdata[rswc_pkg::ST_SENSE_BIT];
      status_r[rswc_pkg::ST_SUSP_BIT]  <= io_wdata[rswc_pkg::ST_SUSP_BIT];
      status_r[rswc_pkg::ST_LVRBOR_BIT] <= status_r[rswc_pkg::ST_LVRBOR_BIT]
                                           & io_wdata[rswc_pkg::ST_LVRBOR_BIT];
      status_r[rswc_pkg::ST_WDR_BIT]   <= status_r[rswc_pkg::ST_WDR_BIT]
                                           & io_wdata[rswc_pkg::ST_WDR_BIT];
    end
  end

  // clock configuration
  always_ff @(posedge clk) begin
    if (rst || (state_nxt == rswc_pkg::SQ_HOLD && state_r != rswc_pkg::SQ_HOLD)) begin
      clk_cfg_r <= rswc_pkg::CFG_RST;
    end else if (state_nxt == rswc_pkg::SQ_WDR) begin
      clk_cfg_r[rswc_pkg::CFG_EXT_EN_BIT] <= 1'b0;
    end else if (wr_cfg) begin
      clk_cfg_r <= io_wdata;
    end
  end

  // wake clock mode sampled at suspend entry
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ext_r <= 1'b0;
    end else if (state_nxt == rswc_pkg::SQ_SUSPEND && state_r == rswc_pkg::SQ_RUN) begin
      wake_ext_r <= clk_cfg_r[rswc_pkg::CFG_EXT_EN_BIT];
    end
  end

  // wake timer pending flag, a new time-out beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_timer_pend_r <= 1'b0;
    end else if (wt_expire) begin
      wake_timer_pend_r <= 1'b1;
    end else if (wake_timer_pend_clr) begin
      wake_timer_pend_r <= 1'b0;
    end
  end

  // interrupt hold-off for one instruction after resume
  always_ff @(posedge clk) begin
    if (rst) begin
      from_susp_r <= 1'b0;
      irq_defer_r <= 1'b0;
    end else begin
      if (state_nxt == rswc_pkg::SQ_SUSPEND) begin
        from_susp_r <= 1'b1;
      end else if (state_nxt == rswc_pkg::SQ_RUN || state_nxt == rswc_pkg::SQ_HOLD) begin
        from_susp_r <= 1'b0;
      end
      if (state_nxt == rswc_pkg::SQ_RUN && state_r != rswc_pkg::SQ_RUN && from_susp_r) begin
        irq_defer_r <= 1'b1;
      end else if (cpu_instr_done || state_r != rswc_pkg::SQ_RUN) begin
        irq_defer_r <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_reset_r    <= 1'b1;
      cpu_run_r      <= 1'b0;
      reset_vector_r <= rswc_pkg::RESET_VECTOR;
      int_osc_on_r   <= 1'b1;
      ext_osc_on_r   <= 1'b0;
      ext_clk_sel_r  <= 1'b0;
      suspended_r    <= 1'b0;
      lvr_armed_r    <= 1'b1;
    end else begin
      cpu_reset_r    <= state_nxt == rswc_pkg::SQ_HOLD || state_nxt == rswc_pkg::SQ_START
                        || state_nxt == rswc_pkg::SQ_WDR;
      cpu_run_r      <= state_nxt == rswc_pkg::SQ_RUN;
      reset_vector_r <= rswc_pkg::RESET_VECTOR;
      int_osc_on_r   <= state_nxt != rswc_pkg::SQ_SUSPEND && state_nxt != rswc_pkg::SQ_EXT_WAIT
                        && !ext_sel_nxt;
      ext_osc_on_r   <= state_nxt == rswc_pkg::SQ_EXT_WAIT
                        || (ext_sel_nxt && state_nxt != rswc_pkg::SQ_SUSPEND);
      ext_clk_sel_r  <= ext_sel_nxt;
      suspended_r    <= state_nxt == rswc_pkg::SQ_SUSPEND;
      lvr_armed_r    <= state_nxt != rswc_pkg::SQ_SUSPEND
                        && !clk_cfg_r[rswc_pkg::CFG_LVR_DIS_BIT];
    end
  end

  // watchdog stops outside normal execution
  rswc_watchdog #(
    .TIMEOUT (WDOG_TICKS)
  ) u_wdog (
    .clk    (clk),
    .rst    (rst),
    .tick   (lp_tick),
    .run    (state_r == rswc_pkg::SQ_RUN),
    .clear  (wr_wdog || cpu_reset_r),
    .roll_r (wd_roll)
  );

  // wake timer runs on its enable only
  rswc_wake_timer #(
    .BASE (WAKE_BASE_TICKS)
  ) u_wake (
    .clk      (clk),
    .rst      (rst),
    .tick     (lp_tick),
    .en       (wake_timer_int_en),
    .adj      (clk_cfg_r[rswc_pkg::CFG_ADJ_MSB:rswc_pkg::CFG_ADJ_LSB]),
    .expire_r (wt_expire)
  );

  // checks
  localparam int INT_WAIT_MAX = 60;

  sequence s_int_wake;
    state_r == rswc_pkg::SQ_SUSPEND && wake_any && status_r[rswc_pkg::ST_RUN_BIT]
    && !wake_ext_r && !supply_trip;
  endsequence

  sequence s_int_restart;
    ##1 state_r == rswc_pkg::SQ_INT_START ##[1:INT_WAIT_MAX] state_r == rswc_pkg::SQ_INT_DELAY;
  endsequence

  a_bor_holds_reset: assert property (@(posedge clk) disable iff (rst)
    brownout_reset |=> cpu_reset_r && state_r == rswc_pkg::SQ_HOLD)
    else $error("brown-out did not hold reset");
  a_susp_lvr_off: assert property (@(posedge clk) disable iff (rst)
    state_r == rswc_pkg::SQ_SUSPEND && low_voltage_reset && !brownout_reset
    |=> state_r != rswc_pkg::SQ_HOLD) else $error("low-voltage reset in suspend");
  a_wdr_sets_flag: assert property (@(posedge clk) disable iff (rst)
    state_r == rswc_pkg::SQ_RUN && wd_roll && !supply_trip
    |=> status_r[rswc_pkg::ST_WDR_BIT] && cpu_reset_r)
    else $error("watchdog reset lost");
  a_wdr_hold_len: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == rswc_pkg::SQ_WDR) |-> cnt_r == WDR_HOLD_CYC - 1)
    else $error("watchdog hold length wrong");
  a_susp_entry: assert property (@(posedge clk) disable iff (rst)
    wr_status && io_wdata[rswc_pkg::ST_SUSP_BIT] && !wd_roll && !supply_trip
    |=> suspended_r ##1 !cpu_run_r) else $error("suspend not entered");
  a_susp_clocks_off: assert property (@(posedge clk) disable iff (rst)
    suspended_r |-> !int_osc_on_r && !ext_osc_on_r && !cpu_run_r)
    else $error("oscillator on in suspend");
  a_no_run_no_wake: assert property (@(posedge clk) disable iff (rst)
    state_r == rswc_pkg::SQ_SUSPEND && !status_r[rswc_pkg::ST_RUN_BIT] && !supply_trip
    |=> state_r == rswc_pkg::SQ_SUSPEND) else $error("woke without run bit");
  a_no_wake_idle: assert property (@(posedge clk) disable iff (rst)
    state_r == rswc_pkg::SQ_SUSPEND && !wake_any && !supply_trip
    |=> state_r == rswc_pkg::SQ_SUSPEND) else $error("woke with no source");
  a_int_wake_seq: assert property (@(posedge clk) disable iff (rst)
    s_int_wake |-> s_int_restart) else $error("internal wake sequence wrong");
  a_int_resume_len: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == rswc_pkg::SQ_INT_DELAY) |-> cnt_r == rswc_pkg::INT_RESUME_CYC - 1)
    else $error("internal resume delay wrong");
  a_ext_delay_len: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == rswc_pkg::SQ_EXT_DELAY)
    |-> cnt_r == (clk_cfg_r[rswc_pkg::CFG_DLY_BIT] ? EXT_LONG_CYC - 1
                                                   : rswc_pkg::EXT_SHORT_CYC - 1))
    else $error("external resume delay wrong");
  a_wake_clk_mode: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == rswc_pkg::SQ_SUSPEND)
    |-> wake_ext_r == $past(clk_cfg_r[rswc_pkg::CFG_EXT_EN_BIT]))
    else $error("wake clock mode not sampled");
  a_ext_switch_halt: assert property (@(posedge clk) disable iff (rst)
    state_r == rswc_pkg::SQ_EXT_WAIT
    |-> !cpu_run_r ##1 (!int_osc_on_r || state_r != rswc_pkg::SQ_EXT_WAIT))
    else $error("cpu ran while oscillator settled");
  a_resume_defer: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_run_r) && $past(from_susp_r) |-> irq_defer_r)
    else $error("interrupt not deferred");
endmodule
`default_nettype wire

// File: testbench/rswc_far_side.sv
// far-side model: low-power tick and external oscillator
`timescale 1ns/1ps
`default_nettype none
module rswc_far_side (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // oscillator enable in, tick and stable out
  input  wire logic ext_on,
  output logic      lp_tick,
  output logic      ext_osc_stable
);
  logic [3:0] tick_cnt_r;
  logic [4:0] osc_cnt_r;
  // tick every 16 clocks
  always_ff @(posedge clk) begin
    tick_cnt_r <= rst ? 4'h0 : tick_cnt_r + 4'h1;
    lp_tick    <= !rst && tick_cnt_r == 4'hf;
  end
  // stable 20 clocks after enable
  always_ff @(posedge clk) begin
    osc_cnt_r      <= (rst || !ext_on) ? 5'h00 : osc_cnt_r + {4'h0, osc_cnt_r != 5'h14};
    ext_osc_stable <= !rst && ext_on && osc_cnt_r == 5'h14;
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the reset, suspend and wake sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, io_wr = 1'b0, cpu_instr_done = 1'b0;
  logic        brownout_reset = 1'b0, low_voltage_reset = 1'b0, gpio_int_pend = 1'b0;
  logic        spi_int_pend = 1'b0, other_int_pend = 1'b0, serial_data_line = 1'b1;
  logic        wake_timer_int_en = 1'b0, wake_timer_pend_clr = 1'b0;
  logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, status_r, clk_cfg_r;
  logic        lp_tick, ext_osc_stable, cpu_reset_r, cpu_run_r, irq_defer_r, int_osc_on_r;
  logic        ext_osc_on_r, ext_clk_sel_r, suspended_r, lvr_armed_r, wake_timer_pend_r;
  logic [15:0] reset_vector_r;
  int          mismatches = 0, checks_done = 0, n;
  always #20 clk = ~clk;
  rswc_reset_suspend_wake #(.TSTART_CYC(20), .WDR_HOLD_CYC(30), .EXT_LONG_CYC(40)) dut (
    .clk, .rst, .io_wr, .io_addr, .io_wdata, .cpu_instr_done, .brownout_reset,
    .low_voltage_reset, .ext_osc_stable, .lp_tick, .gpio_int_pend, .spi_int_pend,
    .other_int_pend, .serial_data_line, .wake_timer_int_en, .wake_timer_pend_clr,
    .cpu_reset_r, .cpu_run_r, .irq_defer_r, .reset_vector_r, .int_osc_on_r, .ext_osc_on_r,
    .ext_clk_sel_r, .suspended_r, .lvr_armed_r, .status_r, .clk_cfg_r, .wake_timer_pend_r);
  rswc_far_side far (.clk, .rst, .ext_on(ext_osc_on_r), .lp_tick, .ext_osc_stable);
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  // sel 0 waits on run, sel 1 on wake timer pending
  task automatic wait_lvl(input int sel, input logic lvl);
    n = 0;
    while (((sel == 0) ? cpu_run_r : wake_timer_pend_r) !== lvl && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(n < 5000, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_byte(status_r, 8'h11);
    chk_byte(clk_cfg_r, 8'h00);
    chk_bit(lvr_armed_r, 1'b1);
    wait_lvl(0, 1'b1);
    chk_bit(n >= 19 && n <= 24, 1'b1);
    chk_bit(reset_vector_r == 16'h0000, 1'b1);
    // data line already low at suspend entry
    serial_data_line <= 1'b0;
    wr(8'hff, 8'h09);
    @(negedge clk);
    chk_bit(lvr_armed_r, 1'b0);
    chk_bit(suspended_r, 1'b1);
    @(negedge clk);
    serial_data_line <= 1'b1;
    wait_lvl(0, 1'b1);
    chk_bit(n >= 240 && n <= 262, 1'b1);
    chk_bit(irq_defer_r, 1'b1);
    chk_bit(lvr_armed_r, 1'b1);
    cpu_instr_done <= 1'b1;
    @(posedge clk);
    cpu_instr_done <= 1'b0;
    wr(8'h26, 8'h00);
    chk_bit(irq_defer_r, 1'b0);
    // wake timer wakes from suspend, adjust 2
    wr(8'hf8, 8'h20);
    wake_timer_int_en <= 1'b1;
    wr(8'hff, 8'h0d);
    repeat (100) @(negedge clk);
    chk_bit(suspended_r, 1'b1);
    chk_bit(int_osc_on_r, 1'b0);
    // low-voltage trip ignored while suspended
    low_voltage_reset <= 1'b1;
    repeat (5) @(negedge clk);
    chk_bit(suspended_r, 1'b1);
    low_voltage_reset <= 1'b0;
    wait_lvl(1, 1'b1);
    chk_bit(n >= 130 && n <= 160, 1'b1);
    wait_lvl(0, 1'b1);
    wake_timer_int_en <= 1'b0;
    wake_timer_pend_clr <= 1'b1;
    cpu_instr_done <= 1'b1;
    @(posedge clk);
    wake_timer_pend_clr <= 1'b0;
    cpu_instr_done <= 1'b0;
    wr(8'h26, 8'h00);
    chk_bit(wake_timer_pend_r, 1'b0);
    // switch to external clock, short delay
    wr(8'hf8, 8'h01);
    @(negedge clk);
    @(negedge clk);
    chk_bit(ext_osc_on_r, 1'b1);
    chk_bit(cpu_run_r, 1'b0);
    wait_lvl(0, 1'b1);
    chk_bit(n >= 3210 && n <= 3240, 1'b1);
    chk_bit(ext_clk_sel_r, 1'b1);
    // wake in external mode on a gpio interrupt, long delay
    wr(8'hf8, 8'h81);
    gpio_int_pend <= 1'b1;
    wr(8'hff, 8'h09);
    @(negedge clk);
    chk_bit(suspended_r, 1'b1);
    chk_bit(ext_osc_on_r, 1'b0);
    wait_lvl(0, 1'b1);
    chk_bit(n >= 60 && n <= 68, 1'b1);
    chk_bit(ext_clk_sel_r, 1'b1);
    chk_bit(irq_defer_r, 1'b1);
    gpio_int_pend <= 1'b0;
    cpu_instr_done <= 1'b1;
    @(posedge clk);
    cpu_instr_done <= 1'b0;
    wr(8'h26, 8'h00);
    repeat (3) begin
      repeat (90) @(negedge clk);
      wr(8'h26, 8'h5a);
    end
    chk_bit(cpu_reset_r, 1'b0);
    wait_lvl(0, 1'b0);
    @(negedge clk);
    chk_bit(cpu_reset_r, 1'b1);
    chk_bit(status_r[6], 1'b1);
    chk_bit(clk_cfg_r[0], 1'b0);
    wait_lvl(0, 1'b1);
    chk_bit(n >= 28 && n <= 33, 1'b1);
    // pending interrupts without the run bit never wake
    spi_int_pend <= 1'b1;
    other_int_pend <= 1'b1;
    wr(8'hff, 8'h08);
    repeat (20) @(negedge clk);
    chk_bit(suspended_r, 1'b1);
    chk_bit(cpu_run_r, 1'b0);
    @(posedge clk);
    brownout_reset <= 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(cpu_reset_r, 1'b1);
    chk_byte(status_r, 8'h11);
    brownout_reset <= 1'b0;
    spi_int_pend <= 1'b0;
    other_int_pend <= 1'b0;
    wait_lvl(0, 1'b1);
    chk_bit(n >= 19 && n <= 26, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
